// ---- hw/tft_panel_timing_palette.sv ----
// TFT panel timing registers, configuration command and palette output.
// Assumes an APB master on pclk and a free running link_clk for the panel.
//
// Contract
// - Palette mode drives entry bits 5-0
// - Enable clear selects STN, set runs TFT
// - Command applies configuration registers as parameters
// - Line period equals horizontal total plus one
// - Display period equals field plus one
// - Display starts at start field exactly
// - Frame period equals vertical total plus one
// - Low byte plus three upper bits
`timescale 1ns/1ps
`default_nettype none
module tft_panel_timing_palette (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        pce,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [tft_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [tft_pkg::DATA_W-1:0]  pwdata,
	output logic      [tft_pkg::DATA_W-1:0]  prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic                        link_clk,
	input  wire logic [tft_pkg::PIX_W-1:0]   pixel_index,
	output logic                             pixel_request,
	output logic      [tft_pkg::PAL_W-1:0]   panel_data_bus,
	output logic                             line_sync,
	output logic                             frame_sync,
	output logic                             pixel_shift_clock,
	output logic                             display_active,
	output logic                             stn_select
);
	import tft_pkg::*;

	typedef enum logic {
		CMD_IDLE = 1'b0,
		CMD_WAIT = 1'b1
	} cmd_state_t;

	// Register file, pclk domain
	logic [LO_W-1:0]  cfg_q;
	logic [LO_W-1:0]  hl_lo_q;
	logic [HI_W-1:0]  hl_hi_q;
	logic [LO_W-1:0]  hd_lo_q;
	logic [HI_W-1:0]  hd_hi_q;
	logic [LO_W-1:0]  hs_lo_q;
	logic [HI_W-1:0]  hs_hi_q;
	logic [LO_W-1:0]  vl_lo_q;
	logic [HI_W-1:0]  vl_hi_q;
	logic [1:0]       fmt_q;
	logic [PAL_W-1:0] pal_q [PAL_N];
	logic [DATA_W-1:0] prdata_q;
	logic             rd_ok_q;

	// Command snapshot, steady while the link side copies it
	cmd_state_t       state_q;
	cmd_state_t       state_d;
	logic             req_q;
	logic             sh_en_q;
	logic             sh_pal_mode_q;
	logic [1:0]       sh_fmt_q;
	logic [TIM_W-1:0] sh_hl_q;
	logic [TIM_W-1:0] sh_hd_q;
	logic [TIM_W-1:0] sh_hs_q;
	logic [TIM_W-1:0] sh_vl_q;
	logic [PAL_W-1:0] sh_pal_q [PAL_N];
	logic             ack_s;

	// APB decode
	wire [IDX_W-1:0] idx      = paddr[ADDR_W-1:2];
	wire [IDX_W-1:0] pal_off  = idx - IDX_PAL_FIRST;
	wire [ENT_W-1:0] pal_sel  = pal_off[ENT_W-1:0];
	wire             aligned  = (paddr[1:0] == 2'b00);
	wire             hit_cfg  = (idx == IDX_CONFIG);
	wire             hit_htl  = (idx == IDX_HL_LO);
	wire             hit_hth  = (idx == IDX_HL_HI);
	wire             hit_hdl  = (idx == IDX_HD_LO);
	wire             hit_hdh  = (idx == IDX_HD_HI);
	wire             hit_hsl  = (idx == IDX_HS_LO);
	wire             hit_hsh  = (idx == IDX_HS_HI);
	wire             hit_vtl  = (idx == IDX_VL_LO);
	wire             hit_vth  = (idx == IDX_VL_HI);
	wire             hit_pal  = (idx >= IDX_PAL_FIRST) && (idx <= IDX_PAL_LAST);
	wire             hit_cmd  = (idx == IDX_COMMAND);
	wire             hit_fmt  = (idx == IDX_FORMAT);
	wire             hit_st   = (idx == IDX_STATUS);
	wire             mapped   = aligned && (hit_cfg || hit_htl || hit_hth || hit_hdl
		|| hit_hdh || hit_hsl || hit_hsh || hit_vtl || hit_vth || hit_pal || hit_cmd
		|| hit_fmt || hit_st);
	wire             setup    = pce && psel && !penable;
	wire             take     = psel && penable && pready;
	wire             wr       = take && pwrite && mapped;
	wire             cmd_wr   = wr && hit_cmd;

	// Timing fields as software sees them
	wire [TIM_W-1:0] hl_field = join_field(hl_lo_q, hl_hi_q);
	wire [TIM_W-1:0] hd_field = join_field(hd_lo_q, hd_hi_q);
	wire [TIM_W-1:0] hs_field = join_field(hs_lo_q, hs_hi_q);
	wire [TIM_W-1:0] vl_field = join_field(vl_lo_q, vl_hi_q);

	wire [DATA_W-1:0] status_word = {30'h0, cfg_q[CFG_EN_BIT] && state_q == CMD_IDLE,
		state_q == CMD_WAIT};

	wire [DATA_W-1:0] rd_word =
		!mapped ? 32'h0 :
		hit_cfg ? {24'h0, cfg_q} :
		hit_htl ? {24'h0, hl_lo_q} :
		hit_hth ? {28'h0, hl_hi_q} :
		hit_hdl ? {24'h0, hd_lo_q} :
		hit_hdh ? {28'h0, hd_hi_q} :
		hit_hsl ? {24'h0, hs_lo_q} :
		hit_hsh ? {28'h0, hs_hi_q} :
		hit_vtl ? {24'h0, vl_lo_q} :
		hit_vth ? {28'h0, vl_hi_q} :
		hit_pal ? {26'h0, pal_q[pal_sel]} :
		hit_fmt ? {30'h0, fmt_q} :
		hit_st  ? status_word : 32'h0;

	assign pready  = pce && rd_ok_q;
	assign pslverr = psel && penable && pready && !mapped;
	assign prdata  = prdata_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= '0;
			rd_ok_q  <= 1'b0;
		end else if (pce) begin
			rd_ok_q <= setup;
			if (setup) begin
				prdata_q <= rd_word;
			end
		end
	end

	// Upper registers keep bit 3 as written; it steers nothing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q   <= RST_CONFIG;
			hl_lo_q <= RST_HL_LO;
			hl_hi_q <= RST_HL_HI;
			hd_lo_q <= RST_HD_LO;
			hd_hi_q <= RST_HD_HI;
			hs_lo_q <= RST_HS_LO;
			hs_hi_q <= RST_HS_HI;
			vl_lo_q <= RST_VL_LO;
			vl_hi_q <= RST_VL_HI;
			fmt_q   <= RST_FORMAT;
		end else if (wr) begin
			if (hit_cfg) cfg_q <= pwdata[LO_W-1:0];
			if (hit_htl) hl_lo_q <= pwdata[LO_W-1:0];
			if (hit_hth) hl_hi_q <= pwdata[HI_W-1:0];
			if (hit_hdl) hd_lo_q <= pwdata[LO_W-1:0];
			if (hit_hdh) hd_hi_q <= pwdata[HI_W-1:0];
			if (hit_hsl) hs_lo_q <= pwdata[LO_W-1:0];
			if (hit_hsh) hs_hi_q <= pwdata[HI_W-1:0];
			if (hit_vtl) vl_lo_q <= pwdata[LO_W-1:0];
			if (hit_vth) vl_hi_q <= pwdata[HI_W-1:0];
			if (hit_fmt) fmt_q <= pwdata[1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < PAL_N; i++) begin
				pal_q[i] <= RST_PAL;
			end
		end else if (wr && hit_pal) begin
			pal_q[pal_sel] <= pwdata[PAL_W-1:0];
		end
	end

	// Command handshake: a command written before the link side has copied the last one is dropped
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			CMD_IDLE: if (cmd_wr) state_d = CMD_WAIT;
			CMD_WAIT: if (ack_s == req_q) state_d = CMD_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= CMD_IDLE;
			req_q   <= 1'b0;
		end else if (pce) begin
			state_q <= state_d;
			if (state_q == CMD_IDLE && cmd_wr) begin
				req_q <= !req_q;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sh_en_q       <= RST_CONFIG[CFG_EN_BIT];
			sh_pal_mode_q <= RST_CONFIG[CFG_PAL_BIT];
			sh_fmt_q      <= RST_FORMAT;
			sh_hl_q       <= join_field(RST_HL_LO, RST_HL_HI);
			sh_hd_q       <= join_field(RST_HD_LO, RST_HD_HI);
			sh_hs_q       <= join_field(RST_HS_LO, RST_HS_HI);
			sh_vl_q       <= join_field(RST_VL_LO, RST_VL_HI);
			for (int i = 0; i < PAL_N; i++) begin
				sh_pal_q[i] <= RST_PAL;
			end
		end else if (pce && state_q == CMD_IDLE && cmd_wr) begin
			sh_en_q       <= cfg_q[CFG_EN_BIT];
			sh_pal_mode_q <= cfg_q[CFG_PAL_BIT];
			sh_fmt_q      <= fmt_q;
			sh_hl_q       <= hl_field;
			sh_hd_q       <= hd_field;
			sh_hs_q       <= hs_field;
			sh_vl_q       <= vl_field;
			sh_pal_q      <= pal_q;
		end
	end

	// Link clock domain
	logic             lrst_a_q;
	logic             lrst_n_q;
	logic             ce_l;
	logic             req_s;
	logic             ack_q;
	logic             en_act_q;
	logic             pal_mode_act_q;
	logic [1:0]       fmt_act_q;
	logic [TIM_W-1:0] hl_act_q;
	logic [TIM_W-1:0] hd_act_q;
	logic [TIM_W-1:0] hs_act_q;
	logic [TIM_W-1:0] vl_act_q;
	logic [PAL_W-1:0] pal_act_q [PAL_N];
	logic             line_q;
	logic             frame_q;
	logic             active_q;
	logic [PAL_W-1:0] data_q;
	logic             stn_q;
	logic             sck_en_q;

	always_ff @(posedge link_clk or negedge presetn) begin
		if (!presetn) begin
			lrst_a_q <= 1'b0;
			lrst_n_q <= 1'b0;
		end else begin
			lrst_a_q <= 1'b1;
			lrst_n_q <= lrst_a_q;
		end
	end

	bit_sync u_ce_sync  (.clk(link_clk), .rst_n(lrst_n_q), .d(pce),   .q(ce_l));
	bit_sync u_req_sync (.clk(link_clk), .rst_n(lrst_n_q), .d(req_q), .q(req_s));
	bit_sync u_ack_sync (.clk(pclk),     .rst_n(presetn),  .d(ack_q), .q(ack_s));

	wire load = req_s ^ ack_q;

	always_ff @(posedge link_clk or negedge lrst_n_q) begin
		if (!lrst_n_q) begin
			ack_q          <= 1'b0;
			en_act_q       <= RST_CONFIG[CFG_EN_BIT];
			pal_mode_act_q <= RST_CONFIG[CFG_PAL_BIT];
			fmt_act_q      <= RST_FORMAT;
			hl_act_q       <= join_field(RST_HL_LO, RST_HL_HI);
			hd_act_q       <= join_field(RST_HD_LO, RST_HD_HI);
			hs_act_q       <= join_field(RST_HS_LO, RST_HS_HI);
			vl_act_q       <= join_field(RST_VL_LO, RST_VL_HI);
			for (int i = 0; i < PAL_N; i++) begin
				pal_act_q[i] <= RST_PAL;
			end
		end else if (ce_l && load) begin
			ack_q          <= req_s;
			en_act_q       <= sh_en_q;
			pal_mode_act_q <= sh_pal_mode_q;
			fmt_act_q      <= sh_fmt_q;
			hl_act_q       <= sh_hl_q;
			hd_act_q       <= sh_hd_q;
			hs_act_q       <= sh_hs_q;
			vl_act_q       <= sh_vl_q;
			pal_act_q      <= sh_pal_q;
		end
	end

	cfg_if g ();
	assign g.ce   = ce_l;
	assign g.en   = en_act_q;
	assign g.load = ce_l && load;
	assign g.hl   = hl_act_q;
	assign g.hd   = hd_act_q;
	assign g.hs   = hs_act_q;
	assign g.vl   = vl_act_q;

	tim_gen u_gen (.clk(link_clk), .rst_n(lrst_n_q), .g(g));

	wire [ENT_W-1:0] entry    = entry_of(pixel_index, fmt_act_q);
	wire [PAL_W-1:0] pal_pick = pal_act_q[entry];
	wire [PAL_W-1:0] gray_pix = {2'b00, gray_of(pixel_index, fmt_act_q)};
	wire [PAL_W-1:0] pix_out  = pal_mode_act_q ? pal_pick : gray_pix;

	assign pixel_request = ce_l && g.active;

	always_ff @(posedge link_clk or negedge lrst_n_q) begin
		if (!lrst_n_q) begin
			line_q   <= 1'b0;
			frame_q  <= 1'b0;
			active_q <= 1'b0;
			data_q   <= '0;
			stn_q    <= 1'b1;
		end else if (ce_l) begin
			line_q   <= g.line;
			frame_q  <= g.frame;
			active_q <= g.active;
			data_q   <= g.active ? pix_out : '0;
			stn_q    <= !en_act_q;
		end
	end

	// Gate changes while the clock is low so no pulse is cut short
	always_ff @(negedge link_clk or negedge lrst_n_q) begin
		if (!lrst_n_q) begin
			sck_en_q <= 1'b0;
		end else begin
			sck_en_q <= en_act_q && ce_l;
		end
	end

	assign pixel_shift_clock = link_clk && sck_en_q;
	assign panel_data_bus    = data_q;
	assign line_sync         = line_q;
	assign frame_sync        = frame_q;
	assign display_active    = active_q;
	assign stn_select        = stn_q;

	sequence s_cmd_issue;
		pce && state_q == CMD_IDLE && cmd_wr;
	endsequence

	a_cmd_issue: assert property (@(posedge pclk) disable iff (!presetn)
		s_cmd_issue |=> state_q == CMD_WAIT && req_q != $past(req_q)
		&& sh_hl_q == $past(hl_field) && sh_vl_q == $past(vl_field))
		else $error("command did not capture the timing registers");
	a_cmd_busy: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == CMD_WAIT && cmd_wr |=> $stable(req_q) && $stable(sh_hl_q))
		else $error("command taken while the previous one was pending");
	a_field_join: assert property (@(posedge pclk) disable iff (!presetn)
		wr && hit_hth |=> hl_field == {$past(pwdata[2:0]), hl_lo_q})
		else $error("horizontal total field not joined from its two registers");
	a_link_load: assert property (@(posedge link_clk) disable iff (!lrst_n_q)
		ce_l && load |=> hl_act_q == $past(sh_hl_q) && hs_act_q == $past(sh_hs_q) && !load)
		else $error("link side did not adopt the command snapshot");
	a_palette_out: assert property (@(posedge link_clk) disable iff (!lrst_n_q)
		ce_l && pal_mode_act_q && g.active |=> panel_data_bus == $past(pal_pick))
		else $error("panel data is not the selected palette entry");
	a_panel_off: assert property (@(posedge link_clk) disable iff (!lrst_n_q)
		ce_l && !en_act_q |=> !line_sync && !frame_sync && panel_data_bus == '0 && stn_select)
		else $error("panel output active while the interface is disabled");
endmodule
`default_nettype wire

// ---- hw/tft_pkg.sv ----
// Constants, types and helpers for the TFT panel timing and palette block.
// Assumes register indices times four form the APB byte address.
`default_nettype none
package tft_pkg;
	localparam int unsigned ADDR_W  = 18;
	localparam int unsigned IDX_W   = 16;
	localparam int unsigned DATA_W  = 32;
	localparam int unsigned TIM_W   = 11;
	localparam int unsigned LO_W    = 8;
	localparam int unsigned HI_W    = 4;
	localparam int unsigned PAL_W   = 6;
	localparam int unsigned PAL_N   = 16;
	localparam int unsigned PIX_W   = 4;
	localparam int unsigned ENT_W   = 4;

	localparam logic [IDX_W-1:0] IDX_CONFIG    = 16'h8034;
	localparam logic [IDX_W-1:0] IDX_HL_LO     = 16'h8035;
	localparam logic [IDX_W-1:0] IDX_HL_HI     = 16'h8036;
	localparam logic [IDX_W-1:0] IDX_HD_LO     = 16'h8037;
	localparam logic [IDX_W-1:0] IDX_HD_HI     = 16'h8038;
	localparam logic [IDX_W-1:0] IDX_HS_LO     = 16'h8039;
	localparam logic [IDX_W-1:0] IDX_HS_HI     = 16'h803A;
	localparam logic [IDX_W-1:0] IDX_VL_LO     = 16'h803B;
	localparam logic [IDX_W-1:0] IDX_VL_HI     = 16'h803C;
	localparam logic [IDX_W-1:0] IDX_PAL_FIRST = 16'h8063;
	localparam logic [IDX_W-1:0] IDX_PAL_LAST  = 16'h8072;
	localparam logic [IDX_W-1:0] IDX_COMMAND   = 16'h8080;
	localparam logic [IDX_W-1:0] IDX_FORMAT    = 16'h8081;
	localparam logic [IDX_W-1:0] IDX_STATUS    = 16'h8082;

	localparam logic [LO_W-1:0]  RST_CONFIG = 8'h00;
	localparam logic [LO_W-1:0]  RST_HL_LO  = 8'h00;
	localparam logic [HI_W-1:0]  RST_HL_HI  = 4'h1;
	localparam logic [LO_W-1:0]  RST_HD_LO  = 8'h3F;
	localparam logic [HI_W-1:0]  RST_HD_HI  = 4'h1;
	localparam logic [LO_W-1:0]  RST_HS_LO  = 8'h46;
	localparam logic [HI_W-1:0]  RST_HS_HI  = 4'h0;
	localparam logic [LO_W-1:0]  RST_VL_LO  = 8'h07;
	localparam logic [HI_W-1:0]  RST_VL_HI  = 4'h1;
	localparam logic [PAL_W-1:0] RST_PAL    = 6'h00;

	localparam int unsigned CFG_EN_BIT   = 0;
	localparam int unsigned CFG_PAL_BIT  = 1;
	localparam int unsigned ST_BUSY_BIT  = 0;
	localparam int unsigned ST_TFT_BIT   = 1;

	typedef enum logic [1:0] {
		FMT_1BPP = 2'b00,
		FMT_2BPP = 2'b01,
		FMT_4BPP = 2'b10
	} fmt_t;

	localparam logic [1:0] RST_FORMAT = 2'b00;

	// Joins a low byte and the three field bits of the upper register
	function automatic logic [TIM_W-1:0] join_field(input logic [LO_W-1:0] lo,
		input logic [HI_W-1:0] hi);
		join_field = {hi[2:0], lo};
	endfunction

	// Palette entry selected by a pixel of the given depth
	function automatic logic [ENT_W-1:0] entry_of(input logic [PIX_W-1:0] pix,
		input logic [1:0] fmt);
		case (fmt)
			FMT_1BPP: entry_of = {3'h0, pix[0]};
			FMT_2BPP: entry_of = {2'h0, pix[1:0]};
			default:  entry_of = pix;
		endcase
	endfunction

	// Grey level on the low four data lines
	function automatic logic [PIX_W-1:0] gray_of(input logic [PIX_W-1:0] pix,
		input logic [1:0] fmt);
		case (fmt)
			FMT_1BPP: gray_of = {4{pix[0]}};
			FMT_2BPP: gray_of = {2{pix[1:0]}};
			default:  gray_of = pix;
		endcase
	endfunction
endpackage
`default_nettype wire

// ---- hw/cfg_if.sv ----
// Live timing settings and raster state between the top and the generator.
// Assumes every signal belongs to the link clock domain.
`timescale 1ns/1ps
`default_nettype none
interface cfg_if;
	import tft_pkg::*;
	logic             ce;
	logic             en;
	logic             load;
	logic [TIM_W-1:0] hl;
	logic [TIM_W-1:0] hd;
	logic [TIM_W-1:0] hs;
	logic [TIM_W-1:0] vl;
	logic             line;
	logic             frame;
	logic             active;
	modport src (output ce, en, load, hl, hd, hs, vl, input line, frame, active);
	modport gen (input ce, en, load, hl, hd, hs, vl, output line, frame, active);
endinterface
`default_nettype wire

// ---- hw/bit_sync.sv ----
// Two flip-flop synchroniser for levels and toggles.
// Assumes the input is steady long enough for the destination clock.
`timescale 1ns/1ps
`default_nettype none
module bit_sync (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic d,
	output logic      q
);
	logic meta_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= 1'b0;
			q      <= 1'b0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ---- hw/tim_gen.sv ----
// Pixel and line counters for the panel raster.
// Assumes settings change only together with the load strobe.
`timescale 1ns/1ps
`default_nettype none
module tim_gen (
	input  wire logic clk,
	input  wire logic rst_n,
	cfg_if.gen        g
);
	import tft_pkg::*;

	logic [TIM_W-1:0] h_q;
	logic [TIM_W-1:0] h_d;
	logic [TIM_W-1:0] v_q;
	logic [TIM_W-1:0] v_d;
	logic [TIM_W:0]   run_q;

	wire            h_end   = (h_q == g.hl);
	wire            v_end   = (v_q == g.vl);
	wire            restart = g.load || !g.en;
	wire [TIM_W:0]  act_end = {1'b0, g.hs} + {1'b0, g.hd};

	assign h_d = (restart || h_end) ? '0 : h_q + 1'b1;
	assign v_d = restart ? '0 : !h_end ? v_q : v_end ? '0 : v_q + 1'b1;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			h_q <= '0;
			v_q <= '0;
		end else if (g.ce) begin
			h_q <= h_d;
			v_q <= v_d;
		end
	end

	assign g.line   = g.en && (h_q == '0);
	assign g.frame  = g.en && (v_q == '0);
	assign g.active = g.en && (h_q >= g.hs) && ({1'b0, h_q} <= act_end);

	// Length of the current active run, checked below
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run_q <= '0;
		end else if (g.ce) begin
			run_q <= (g.load || !g.active) ? '0 : run_q + 1'b1;
		end
	end

	sequence s_line_end;
		g.ce && g.en && !g.load && h_end;
	endsequence

	a_h_wrap: assert property (@(posedge clk) disable iff (!rst_n)
		s_line_end |=> h_q == '0)
		else $error("pixel counter did not wrap at horizontal total");
	a_v_step: assert property (@(posedge clk) disable iff (!rst_n)
		s_line_end and !v_end |=> v_q == TIM_W'($past(v_q) + 1'b1))
		else $error("line counter did not advance at line end");
	a_v_wrap: assert property (@(posedge clk) disable iff (!rst_n)
		s_line_end and v_end |=> v_q == '0 && h_q == '0)
		else $error("line counter did not wrap at vertical total");
	a_active_start: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(g.active) |-> h_q == g.hs)
		else $error("display period began away from start position");
	a_active_len: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(g.active) && !$past(g.load) && (act_end < {1'b0, g.hl})
		|-> run_q == {1'b0, g.hd} + 12'h001)
		else $error("display period length differs from field plus one");
endmodule
`default_nettype wire

// ---- tb/panel_model.sv ----
// Panel model: feeds pixel values and measures sync, active and data timing.
// Assumes the block's panel outputs are registered on link_clk.
`timescale 1ns/1ps
`default_nettype none
module panel_model (
	input  wire logic                       link_clk,
	input  wire logic                       pixel_request,
	input  wire logic [tft_pkg::PAL_W-1:0]  panel_data_bus,
	input  wire logic                       line_sync,
	input  wire logic                       frame_sync,
	input  wire logic                       display_active,
	input  wire logic                       pixel_shift_clock,
	input  wire logic [tft_pkg::PIX_W-1:0]  pix_val,
	output logic      [tft_pkg::PIX_W-1:0]  pixel_index,
	output logic      [15:0]                line_len,
	output logic      [15:0]                act_start,
	output logic      [15:0]                act_len,
	output logic      [15:0]                frame_len,
	output logic      [15:0]                shifts,
	output logic      [tft_pkg::PAL_W-1:0]  last_data
);
	import tft_pkg::*;
	logic [15:0] h_q = 16'h0;
	logic [15:0] n_q = 16'h0;
	logic [15:0] ln_q = 16'h0;
	logic        act_q = 1'b0;
	// Outside a request the pixel lines show the inverse value
	assign pixel_index = pixel_request ? pix_val : ~pix_val;
	initial begin
		{line_len, act_start, act_len, frame_len, shifts, last_data} = '0;
	end
	always @(posedge pixel_shift_clock) shifts <= shifts + 16'h1;
	always @(posedge link_clk) begin
		act_q <= display_active;
		h_q   <= line_sync ? 16'h1 : h_q + 16'h1;
		n_q   <= line_sync ? {15'h0, display_active} : n_q + {15'h0, display_active};
		if (display_active && !act_q) act_start <= h_q;
		if (display_active) last_data <= panel_data_bus;
		if (line_sync) begin
			line_len <= h_q;
			act_len  <= n_q;
			ln_q     <= frame_sync ? 16'h1 : ln_q + 16'h1;
			if (frame_sync) frame_len <= ln_q;
		end
	end
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench: APB register access, command, raster and palette.
// Assumes the panel model stands on the link side.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import tft_pkg::*;
	logic                pclk, link_clk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [ADDR_W-1:0]   paddr;
	logic [DATA_W-1:0]   pwdata, prdata, rd;
	logic                err, pixel_request, line_sync, frame_sync, pixel_shift_clock;
	logic                display_active, stn_select;
	logic [PIX_W-1:0]    pixel_index, pix_val;
	logic [PAL_W-1:0]    panel_data_bus, last_data;
	logic [15:0]         line_len, act_start, act_len, frame_len, shifts;
	logic [PAL_W-1:0]    pal [PAL_N];
	logic [IDX_W-1:0]    ri [7] = '{IDX_HL_HI, IDX_HD_LO, IDX_HD_HI, IDX_HS_LO, IDX_HS_HI,
		IDX_VL_LO, IDX_VL_HI};
	logic [7:0]          rv [7] = '{8'h01, 8'h3F, 8'h01, 8'h46, 8'h00, 8'h07, 8'h01};
	int                  mismatches = 0;
	int                  checks = 0;

	tft_panel_timing_palette tft_panel_timing_palette_i (
		.pclk(pclk), .presetn(presetn), .pce(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link_clk(link_clk), .pixel_index(pixel_index),
		.pixel_request(pixel_request), .panel_data_bus(panel_data_bus),
		.line_sync(line_sync), .frame_sync(frame_sync),
		.pixel_shift_clock(pixel_shift_clock), .display_active(display_active),
		.stn_select(stn_select)
	);
	panel_model panel_model_i (
		.link_clk(link_clk), .pixel_request(pixel_request), .panel_data_bus(panel_data_bus),
		.line_sync(line_sync), .frame_sync(frame_sync), .display_active(display_active),
		.pixel_shift_clock(pixel_shift_clock), .pix_val(pix_val),
		.pixel_index(pixel_index), .line_len(line_len), .act_start(act_start),
		.act_len(act_len), .frame_len(frame_len), .shifts(shifts), .last_data(last_data)
	);

	always #10 pclk = ~pclk;
	initial begin
		#4;
		forever #15 link_clk = ~link_clk;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic finish_test;
		if (mismatches == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic apb(input logic wr_en, input logic [IDX_W-1:0] idx, input logic [31:0] wd);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr_en;
		paddr   <= {idx, 2'b00};
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] wd);
		apb(1'b1, idx, wd);
	endtask
	task automatic rdchk(input string what, input logic [IDX_W-1:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0);
		check(what, rd, exp);
	endtask
	// Bits 6-4 set, bit 7 and bit 3 left zero
	task automatic wpair(input logic [IDX_W-1:0] idx, input logic [10:0] v);
		wr(idx, 32'(v[7:0]));
		wr(idx + 16'h1, {24'h0, 5'h0E, v[10:8]});
	endtask
	task automatic command;
		wr(IDX_COMMAND, 32'h0);
		do apb(1'b0, IDX_STATUS, 32'h0); while (rd[ST_BUSY_BIT] !== 1'b0);
	endtask
	task automatic settle(input int lines);
		repeat (lines) @(posedge line_sync);
		repeat (2) @(posedge link_clk);
	endtask

	task automatic t_reset;
		check("stn_rst", 32'(stn_select), 32'h1);
		for (int i = 0; i < 7; i++) rdchk("reset_val", ri[i], 32'(rv[i]));
		apb(1'b0, 16'h8000, 32'h0);
		check("unmapped_err", 32'(err), 32'h1);
	endtask
	task automatic t_timing;
		logic [15:0] cnt;
		wpair(IDX_HL_LO, 11'h123);
		wpair(IDX_HD_LO, 11'h00B);
		wpair(IDX_HS_LO, 11'h10A);
		wpair(IDX_VL_LO, 11'h002);
		rdchk("hl_hi", IDX_HL_HI, 32'h01);
		rdchk("hs_hi", IDX_HS_HI, 32'h01);
		for (int i = 0; i < PAL_N; i++) wr(IDX_PAL_FIRST + IDX_W'(i), 32'(pal[i]));
		wr(IDX_FORMAT, 32'h2);
		wr(IDX_CONFIG, 32'h3);
		command();
		rdchk("status_on", IDX_STATUS, 32'h2);
		repeat (2) @(posedge frame_sync);
		settle(2);
		check("line_len", 32'(line_len), 32'h124);
		check("act_len", 32'(act_len), 32'h00C);
		check("act_start", 32'(act_start), 32'h10A);
		check("frame_len", 32'(frame_len), 32'h3);
		check("stn_on", 32'(stn_select), 32'h0);
		@(posedge link_clk);
		cnt = shifts;
		repeat (20) @(posedge link_clk);
		check("shift_run", 32'(16'(shifts - cnt)), 32'h14);
		wpair(IDX_HL_LO, 11'h12F);
		settle(3);
		check("line_held", 32'(line_len), 32'h124);
	endtask
	task automatic t_palette;
		for (int i = 0; i < PAL_N; i++) begin
			@(posedge link_clk);
			pix_val <= PIX_W'(i);
			settle(2);
			check("pal_data", 32'(last_data), 32'(pal[i]));
		end
		@(posedge link_clk);
		pix_val <= 4'hE;
		for (int f = 0; f < 2; f++) begin
			wr(IDX_FORMAT, 32'(f));
			command();
			settle(2);
			check("pal_depth", 32'(last_data), 32'(pal[f * 2]));
		end
		// Grey mode, 2 bit pixel 10b repeated on the low data lines
		wr(IDX_CONFIG, 32'h1);
		command();
		settle(2);
		check("gray_data", 32'(last_data), 32'h0A);
		check("line_new", 32'(line_len), 32'h130);
	endtask
	task automatic t_disable;
		logic [15:0] cnt;
		wr(IDX_CONFIG, 32'h2);
		wr(IDX_COMMAND, 32'h0);
		rdchk("status_busy", IDX_STATUS, 32'h1);
		command();
		rdchk("status_off", IDX_STATUS, 32'h0);
		repeat (4) @(posedge link_clk);
		check("stn_off", 32'(stn_select), 32'h1);
		cnt = shifts;
		repeat (20) @(posedge link_clk);
		check("shift_idle", 32'(shifts), 32'(cnt));
	endtask

	initial begin
		{pclk, link_clk, presetn, psel, penable, pwrite} = '0;
		paddr = '0;
		pwdata = '0;
		pix_val = '0;
		for (int i = 0; i < PAL_N; i++) pal[i] = PAL_W'(i * 7 + 5);
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_timing();
		t_palette();
		t_disable();
		finish_test();
	end
	initial begin
		#1000000;
		mismatches++;
		finish_test();
	end
endmodule
`default_nettype wire
